/* File: shared/cpc_map.svh */
`ifndef CPC_MAP_SVH
`define CPC_MAP_SVH

// Register offsets on the register port.
`define CPC_ADDR_CTRL          8'h2b
`define CPC_ADDR_OVP_STAT      8'h2c
`define CPC_ADDR_OVP_FLAG_MASK 8'h2d
`define CPC_ADDR_FILTER        8'h2e

// Reset values.
`define CPC_RST_BYTE           8'h00

// Field positions of charge_control.
`define CPC_CTRL_SS_HI         7
`define CPC_CTRL_SS_LO         5
`define CPC_CTRL_OVP_DIS       3
`define CPC_CTRL_RISE_LVL      2
`define CPC_CTRL_SNS_SEL       1
`define CPC_CTRL_PD_EN         0

// Field positions of the status, flag/mask and filter registers.
`define CPC_STAT_LIVE          0
`define CPC_FM_FLAG            4
`define CPC_FM_MASK            0
`define CPC_FILT_BVL           4
`define CPC_FILT_BCL           3

// Clock rate and timer width.
`define CPC_CLK_MHZ            64'd40
`define CPC_TMR_W              32

// Soft-start timeout figures in microseconds.
`define CPC_SS_T1_US           64'd12500
`define CPC_SS_T2_US           64'd25000
`define CPC_SS_T3_US           64'd50000
`define CPC_SS_T4_US           64'd100000
`define CPC_SS_T5_US           64'd400000
`define CPC_SS_T6_US           64'd1500000
`define CPC_SS_T7_US           64'd100000000

// Pull-down time in microseconds; a plain default, the real figure is set per part.
`define CPC_PD_T_US            64'd10000

// Error filter figures in microseconds.
`define CPC_FILT_SHORT_US      64'd10
`define CPC_BVL_LONG_US        64'd10000
`define CPC_BCL_LONG_US        64'd5000

`endif

/* File: shared/cpc_pkg.sv */
`include "cpc_map.svh"
package cpc_pkg;

    typedef logic [7:0] cpc_byte_t;

    typedef logic [`CPC_TMR_W-1:0] cpc_count_t;

    typedef enum logic [2:0] {
        CPC_SS_OFF  = 3'h0,
        CPC_SS_T1   = 3'h1,
        CPC_SS_T2   = 3'h2,
        CPC_SS_T3   = 3'h3,
        CPC_SS_T4   = 3'h4,
        CPC_SS_T5   = 3'h5,
        CPC_SS_T6   = 3'h6,
        CPC_SS_T7   = 3'h7
    } cpc_ss_code_e;

endpackage

/* File: design/cpc_timer.sv */
`timescale 1ns/1ps
`include "cpc_map.svh"
module cpc_timer
    import cpc_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Control.
    input  wire logic       start,
    input  wire logic       stop,
    input  wire cpc_count_t load,
    // Status.
    output logic            busy,
    output logic            expired
);

    cpc_count_t cnt_q;

    // A stop wins over a start in the same cycle; a zero load never starts.
    always_ff @(posedge clk_sys) begin
        if (rst || stop) begin
            cnt_q   <= '0;
            busy    <= 1'b0;
            expired <= 1'b0;
        end else if (start) begin
            cnt_q   <= load;
            busy    <= (load != '0);
            expired <= 1'b0;
        end else if (busy) begin
            if (cnt_q == cpc_count_t'(1)) begin
                busy    <= 1'b0;
                expired <= 1'b1;
            end else begin
                expired <= 1'b0;
            end
            cnt_q <= cnt_q - cpc_count_t'(1);
        end else begin
            expired <= 1'b0;
        end
    end

endmodule

/* File: design/cpc_deglitch.sv */
`timescale 1ns/1ps
`include "cpc_map.svh"
module cpc_deglitch
    import cpc_pkg::*;
#(
    parameter cpc_count_t SHORT_CYC = cpc_count_t'(1),
    parameter cpc_count_t LONG_CYC  = cpc_count_t'(1)
)(
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic rst,
    // Raw condition and filter choice.
    input  wire logic raw,
    input  wire logic long_sel,
    // Filtered error.
    output logic      error
);

    cpc_count_t cnt_q;
    cpc_count_t limit;

    assign limit = long_sel ? LONG_CYC : SHORT_CYC;

    // The error rises once the raw condition has held for the whole filter time.
    always_ff @(posedge clk_sys) begin
        if (rst || !raw) begin
            cnt_q <= '0;
            error <= 1'b0;
        end else if (cnt_q >= limit - cpc_count_t'(1)) begin
            error <= 1'b1;
        end else begin
            cnt_q <= cnt_q + cpc_count_t'(1);
        end
    end

endmodule

/* File: design/cpc_regs.sv */
`timescale 1ns/1ps
`include "cpc_map.svh"
module cpc_regs
    import cpc_pkg::*;
#(
    parameter cpc_count_t SS_CYC_1     = cpc_count_t'(`CPC_SS_T1_US * `CPC_CLK_MHZ),
    parameter cpc_count_t SS_CYC_2     = cpc_count_t'(`CPC_SS_T2_US * `CPC_CLK_MHZ),
    parameter cpc_count_t SS_CYC_3     = cpc_count_t'(`CPC_SS_T3_US * `CPC_CLK_MHZ),
    parameter cpc_count_t SS_CYC_4     = cpc_count_t'(`CPC_SS_T4_US * `CPC_CLK_MHZ),
    parameter cpc_count_t SS_CYC_5     = cpc_count_t'(`CPC_SS_T5_US * `CPC_CLK_MHZ),
    parameter cpc_count_t SS_CYC_6     = cpc_count_t'(`CPC_SS_T6_US * `CPC_CLK_MHZ),
    parameter cpc_count_t SS_CYC_7     = cpc_count_t'(`CPC_SS_T7_US * `CPC_CLK_MHZ),
    parameter cpc_count_t PD_CYC       = cpc_count_t'(`CPC_PD_T_US * `CPC_CLK_MHZ),
    parameter cpc_count_t BVL_LONG_CYC = cpc_count_t'(`CPC_BVL_LONG_US * `CPC_CLK_MHZ),
    parameter cpc_count_t BCL_LONG_CYC = cpc_count_t'(`CPC_BCL_LONG_US * `CPC_CLK_MHZ)
)(
    // Clock and reset.
    input  wire logic      clk_sys,
    input  wire logic      rst,
    // Register port from the serial interface front end.
    input  wire cpc_byte_t reg_addr,
    input  wire logic      reg_wr_stb,
    input  wire logic      reg_rd_stb,
    input  wire cpc_byte_t reg_wdata,
    input  wire logic      reg_reset_cmd,
    output cpc_byte_t      reg_rdata,
    output logic           reg_rvalid,
    // Power stage and analog detector inputs.
    input  wire logic      switching_active,
    input  wire logic      bus_current_above_rise,
    input  wire logic      out_overvolt_detect,
    input  wire logic      bus_volt_low_raw,
    input  wire logic      bus_curr_low_raw,
    // Controls to the power stage and analog blocks.
    output logic           output_overvoltage_protect,
    output logic           bus_current_rise_level,
    output logic           sense_resistor_sel,
    output logic           input_pulldown_on,
    output logic           soft_start_fault,
    // Filtered errors and interrupt.
    output logic           bus_voltage_low_error,
    output logic           bus_current_low_error,
    output logic           irq
);

    localparam cpc_count_t FILT_SHORT_CYC = cpc_count_t'(`CPC_FILT_SHORT_US * `CPC_CLK_MHZ);

    // Register fields.
    cpc_ss_code_e ss_code_q;
    logic         ovp_dis_q;
    logic         rise_lvl_q;
    logic         sns_sel_q;
    logic         pd_en_q;
    logic         live_q;
    logic         flag_q;
    logic         mask_q;
    logic         bvl_sel_q;
    logic         bcl_sel_q;

    // Internal strobes and conditions.
    logic         wr_ctrl;
    logic         wr_fm;
    logic         wr_filt;
    logic         rd_fm;
    logic         ovp_cond;
    logic         sw_q;
    logic         sw_rise;
    cpc_count_t   ss_load;
    logic         ss_start;
    logic         ss_stop;
    logic         ss_expired;
    logic         pd_start;
    logic         pd_stop;
    logic         pd_expired;
    cpc_byte_t    rd_byte;

    assign wr_ctrl = reg_wr_stb && (reg_addr == `CPC_ADDR_CTRL);
    assign wr_fm   = reg_wr_stb && (reg_addr == `CPC_ADDR_OVP_FLAG_MASK);
    assign wr_filt = reg_wr_stb && (reg_addr == `CPC_ADDR_FILTER);
    assign rd_fm   = reg_rd_stb && (reg_addr == `CPC_ADDR_OVP_FLAG_MASK);

    // Fields of charge_control that the register-reset command leaves alone.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ss_code_q <= CPC_SS_OFF;
            ovp_dis_q <= 1'b0;
            sns_sel_q <= 1'b0;
        end else if (wr_ctrl) begin
            ss_code_q <= cpc_ss_code_e'(reg_wdata[`CPC_CTRL_SS_HI:`CPC_CTRL_SS_LO]);
            ovp_dis_q <= reg_wdata[`CPC_CTRL_OVP_DIS];
            sns_sel_q <= reg_wdata[`CPC_CTRL_SNS_SEL];
        end
    end

    // The rise level ignores writes while switching; the register-reset command still clears it.
    always_ff @(posedge clk_sys) begin
        if (rst || reg_reset_cmd) begin
            rise_lvl_q <= 1'b0;
        end else if (wr_ctrl && !switching_active) begin
            rise_lvl_q <= reg_wdata[`CPC_CTRL_RISE_LVL];
        end
    end

    // The pull-down enable clears itself when the pull-down time has run out.
    always_ff @(posedge clk_sys) begin
        if (rst || reg_reset_cmd) begin
            pd_en_q <= 1'b0;
        end else if (wr_ctrl) begin
            pd_en_q <= reg_wdata[`CPC_CTRL_PD_EN];
        end else if (pd_expired) begin
            pd_en_q <= 1'b0;
        end
    end

    assign pd_start = wr_ctrl && reg_wdata[`CPC_CTRL_PD_EN] && !reg_reset_cmd;
    assign pd_stop  = reg_reset_cmd || (wr_ctrl && !reg_wdata[`CPC_CTRL_PD_EN]);

    cpc_timer u_pd_timer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .start   (pd_start),
        .stop    (pd_stop),
        .load    (PD_CYC),
        .busy    (input_pulldown_on),
        .expired (pd_expired)
    );

    // Control outputs follow their register bits one cycle later.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            output_overvoltage_protect <= 1'b1;
            bus_current_rise_level     <= 1'b0;
            sense_resistor_sel         <= 1'b0;
        end else begin
            output_overvoltage_protect <= !ovp_dis_q;
            bus_current_rise_level     <= rise_lvl_q;
            sense_resistor_sel         <= sns_sel_q;
        end
    end

    // A disabled protection reports no condition either.
    assign ovp_cond = out_overvolt_detect && !ovp_dis_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            live_q <= 1'b0;
        end else begin
            live_q <= ovp_cond;
        end
    end

    // A new event in the cycle of a clearing read keeps the flag set.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (ovp_cond) begin
            flag_q <= 1'b1;
        end else if (rd_fm) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || reg_reset_cmd) begin
            mask_q <= 1'b0;
        end else if (wr_fm) begin
            mask_q <= reg_wdata[`CPC_FM_MASK];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= flag_q && !mask_q;
        end
    end

    // Filter register; the register-reset command wins over a write.
    always_ff @(posedge clk_sys) begin
        if (rst || reg_reset_cmd) begin
            bvl_sel_q <= 1'b0;
            bcl_sel_q <= 1'b0;
        end else if (wr_filt) begin
            bvl_sel_q <= reg_wdata[`CPC_FILT_BVL];
            bcl_sel_q <= reg_wdata[`CPC_FILT_BCL];
        end
    end

    cpc_deglitch #(
        .SHORT_CYC (FILT_SHORT_CYC),
        .LONG_CYC  (BVL_LONG_CYC)
    ) u_bvl_filter (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .raw      (bus_volt_low_raw),
        .long_sel (bvl_sel_q),
        .error    (bus_voltage_low_error)
    );

    cpc_deglitch #(
        .SHORT_CYC (FILT_SHORT_CYC),
        .LONG_CYC  (BCL_LONG_CYC)
    ) u_bcl_filter (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .raw      (bus_curr_low_raw),
        .long_sel (bcl_sel_q),
        .error    (bus_current_low_error)
    );

    // Soft-start supervision starts on the rising edge of switching.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sw_q <= 1'b0;
        end else begin
            sw_q <= switching_active;
        end
    end

    assign sw_rise = switching_active && !sw_q;

    always_comb begin
        ss_load = '0;
        unique case (ss_code_q)
            CPC_SS_OFF: ss_load = '0;
            CPC_SS_T1:  ss_load = SS_CYC_1;
            CPC_SS_T2:  ss_load = SS_CYC_2;
            CPC_SS_T3:  ss_load = SS_CYC_3;
            CPC_SS_T4:  ss_load = SS_CYC_4;
            CPC_SS_T5:  ss_load = SS_CYC_5;
            CPC_SS_T6:  ss_load = SS_CYC_6;
            CPC_SS_T7:  ss_load = SS_CYC_7;
        endcase
    end

    assign ss_start = sw_rise && (ss_code_q != CPC_SS_OFF);
    assign ss_stop  = !switching_active || bus_current_above_rise;

    cpc_timer u_ss_timer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .start   (ss_start),
        .stop    (ss_stop),
        .load    (ss_load),
        .busy    (),
        .expired (ss_expired)
    );

    // The fault holds until the host rewrites charge_control or resets registers.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            soft_start_fault <= 1'b0;
        end else if (ss_expired) begin
            soft_start_fault <= 1'b1;
        end else if (wr_ctrl || reg_reset_cmd) begin
            soft_start_fault <= 1'b0;
        end
    end

    // Read multiplexer; reserved bits and unmapped offsets read zero.
    always_comb begin
        rd_byte = `CPC_RST_BYTE;
        unique case (reg_addr)
            `CPC_ADDR_CTRL: begin
                rd_byte[`CPC_CTRL_SS_HI:`CPC_CTRL_SS_LO] = ss_code_q;
                rd_byte[`CPC_CTRL_OVP_DIS]  = ovp_dis_q;
                rd_byte[`CPC_CTRL_RISE_LVL] = rise_lvl_q;
                rd_byte[`CPC_CTRL_SNS_SEL]  = sns_sel_q;
                rd_byte[`CPC_CTRL_PD_EN]    = pd_en_q;
            end
            `CPC_ADDR_OVP_STAT: begin
                rd_byte[`CPC_STAT_LIVE] = live_q;
            end
            `CPC_ADDR_OVP_FLAG_MASK: begin
                rd_byte[`CPC_FM_FLAG] = flag_q;
                rd_byte[`CPC_FM_MASK] = mask_q;
            end
            `CPC_ADDR_FILTER: begin
                rd_byte[`CPC_FILT_BVL] = bvl_sel_q;
                rd_byte[`CPC_FILT_BCL] = bcl_sel_q;
            end
            default: rd_byte = `CPC_RST_BYTE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata  <= `CPC_RST_BYTE;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd_stb;
            if (reg_rd_stb) begin
                reg_rdata <= rd_byte;
            end
        end
    end

endmodule

/* File: dv/cpc_host.sv */
`timescale 1ns/1ps
`include "cpc_map.svh"
module cpc_host
    import cpc_pkg::*;
(
    // Clock.
    input  wire logic      clk_sys,
    // Register port.
    output cpc_byte_t      reg_addr,
    output logic           reg_wr_stb,
    output logic           reg_rd_stb,
    output cpc_byte_t      reg_wdata,
    output logic           reg_reset_cmd,
    input  wire cpc_byte_t reg_rdata,
    input  wire logic      reg_rvalid
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr_stb = 1'b0;
        reg_rd_stb = 1'b0;
        reg_reset_cmd = 1'b0;
    end

    // Released address and data are inverted so nothing can lean on stale values.
    task automatic wr(input cpc_byte_t a, input cpc_byte_t d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_stb = 1'b1;
        @(negedge clk_sys);
        reg_wr_stb = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    // Read data is taken in the single cycle that the valid pulse stands,
    // which is the cycle right after the strobe edge.
    task automatic rd(input cpc_byte_t a, output cpc_byte_t d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd_stb = 1'b1;
        @(negedge clk_sys);
        reg_rd_stb = 1'b0;
        reg_addr = ~a;
        d = reg_rvalid ? reg_rdata : 8'hxx;
    endtask

    task automatic rcmd();
        @(negedge clk_sys);
        reg_reset_cmd = 1'b1;
        @(negedge clk_sys);
        reg_reset_cmd = 1'b0;
    endtask
endmodule

/* File: dv/cpc_regs_sva.sv */
`timescale 1ns/1ps
`include "cpc_map.svh"
module cpc_regs_sva
    import cpc_pkg::*;
#(
    parameter cpc_count_t PD_CYC = cpc_count_t'(1)
)(
    // Clock and reset.
    input  wire logic      clk_sys,
    input  wire logic      rst,
    // Register port.
    input  wire cpc_byte_t reg_addr,
    input  wire logic      reg_wr_stb,
    input  wire logic      reg_rd_stb,
    input  wire cpc_byte_t reg_wdata,
    input  wire logic      reg_reset_cmd,
    input  wire logic      reg_rvalid,
    // Power stage and detectors.
    input  wire logic      switching_active,
    input  wire logic      bus_current_above_rise,
    input  wire logic      bus_volt_low_raw,
    input  wire logic      bus_curr_low_raw,
    // Outputs watched.
    input  wire logic      output_overvoltage_protect,
    input  wire logic      bus_current_rise_level,
    input  wire logic      sense_resistor_sel,
    input  wire logic      input_pulldown_on,
    input  wire logic      soft_start_fault,
    input  wire logic      bus_voltage_low_error,
    input  wire logic      bus_current_low_error,
    input  wire logic      irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic       ctrl_wr;
    cpc_count_t pd_cnt_q;

    assign ctrl_wr = reg_wr_stb && (reg_addr == `CPC_ADDR_CTRL);

    // Counts how long the pull-down has stood since the last control write.
    always_ff @(posedge clk_sys) begin
        if (rst || ctrl_wr || !input_pulldown_on) begin
            pd_cnt_q <= '0;
        end else begin
            pd_cnt_q <= pd_cnt_q + 1'b1;
        end
    end

    a_rvalid_one_late: assert property (reg_rd_stb |=> reg_rvalid)
        else $error("read valid missing after read strobe");
    a_rvalid_has_cause: assert property (reg_rvalid |-> $past(reg_rd_stb))
        else $error("read valid without read strobe");
    a_ovp_disable_acts: assert property (ctrl_wr |-> ##2
        output_overvoltage_protect == !$past(reg_wdata[3], 2))
        else $error("protection enable does not follow disable bit");
    a_rise_lvl_held: assert property (ctrl_wr && switching_active && !reg_reset_cmd
        |-> ##2 $stable(bus_current_rise_level))
        else $error("rise level changed while switching");
    a_rise_lvl_taken: assert property (ctrl_wr && !switching_active && !reg_reset_cmd
        |-> ##2 bus_current_rise_level == $past(reg_wdata[2], 2))
        else $error("rise level not taken while idle");
    a_sense_sel_taken: assert property (ctrl_wr
        |-> ##2 sense_resistor_sel == $past(reg_wdata[1], 2))
        else $error("sense resistor select not taken");
    a_pulldown_start: assert property (ctrl_wr && reg_wdata[0] && !reg_reset_cmd
        |=> input_pulldown_on)
        else $error("pull-down did not start");
    a_pulldown_limit: assert property (pd_cnt_q <= PD_CYC)
        else $error("pull-down stood too long");
    a_pulldown_cmd_stop: assert property (reg_reset_cmd ##1 !reg_wr_stb
        |=> !input_pulldown_on)
        else $error("pull-down survived register reset");
    a_irq_flag_holds: assert property (irq && !reg_wr_stb && !reg_rd_stb
        && !$past(reg_wr_stb) && !$past(reg_rd_stb) |=> irq)
        else $error("interrupt dropped without access");
    a_bvl_err_drop: assert property (!bus_volt_low_raw |-> ##2 !bus_voltage_low_error)
        else $error("bus voltage low error without condition");
    a_bcl_err_drop: assert property (!bus_curr_low_raw |-> ##2 !bus_current_low_error)
        else $error("bus current low error without condition");
    a_fault_has_cause: assert property ($rose(soft_start_fault) |->
        $past(switching_active, 3) && !$past(bus_current_above_rise, 3))
        else $error("soft-start fault without cause");
endmodule

bind cpc_regs cpc_regs_sva #(.PD_CYC(PD_CYC)) sva_u (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr_stb(reg_wr_stb),
    .reg_rd_stb(reg_rd_stb), .reg_wdata(reg_wdata), .reg_reset_cmd(reg_reset_cmd),
    .reg_rvalid(reg_rvalid), .switching_active(switching_active),
    .bus_current_above_rise(bus_current_above_rise), .bus_volt_low_raw(bus_volt_low_raw),
    .bus_curr_low_raw(bus_curr_low_raw),
    .output_overvoltage_protect(output_overvoltage_protect),
    .bus_current_rise_level(bus_current_rise_level), .sense_resistor_sel(sense_resistor_sel),
    .input_pulldown_on(input_pulldown_on), .soft_start_fault(soft_start_fault),
    .bus_voltage_low_error(bus_voltage_low_error),
    .bus_current_low_error(bus_current_low_error), .irq(irq)
);

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`include "cpc_map.svh"
module testbench
    import cpc_pkg::*;
;
    localparam int SS_N [8] = '{0, 20, 30, 40, 50, 60, 70, 80};
    localparam int PD_N  = 25;
    localparam int BVL_N = 30;
    localparam int BCL_N = 20;

    logic      clk_sys, rst, wr_stb, rd_stb, rcmd, rvalid, sw, cur_hi, ovp_det;
    logic      bvl_raw, bcl_raw, prot, rise, sns, pd_on, fault, bvl_err, bcl_err, irq;
    cpc_byte_t addr, wdata, rdata;
    int        num_errors, cmp_count;

    cpc_regs #(.SS_CYC_1(SS_N[1]), .SS_CYC_2(SS_N[2]), .SS_CYC_3(SS_N[3]),
        .SS_CYC_4(SS_N[4]), .SS_CYC_5(SS_N[5]), .SS_CYC_6(SS_N[6]), .SS_CYC_7(SS_N[7]),
        .PD_CYC(PD_N), .BVL_LONG_CYC(BVL_N), .BCL_LONG_CYC(BCL_N)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(addr), .reg_wr_stb(wr_stb),
        .reg_rd_stb(rd_stb), .reg_wdata(wdata), .reg_reset_cmd(rcmd), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .switching_active(sw), .bus_current_above_rise(cur_hi),
        .out_overvolt_detect(ovp_det), .bus_volt_low_raw(bvl_raw), .bus_curr_low_raw(bcl_raw),
        .output_overvoltage_protect(prot), .bus_current_rise_level(rise),
        .sense_resistor_sel(sns), .input_pulldown_on(pd_on), .soft_start_fault(fault),
        .bus_voltage_low_error(bvl_err), .bus_current_low_error(bcl_err), .irq(irq));

    cpc_host host_u (.clk_sys(clk_sys), .reg_addr(addr), .reg_wr_stb(wr_stb),
        .reg_rd_stb(rd_stb), .reg_wdata(wdata), .reg_reset_cmd(rcmd), .reg_rdata(rdata),
        .reg_rvalid(rvalid));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input cpc_byte_t exp, input cpc_byte_t got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rchk(input cpc_byte_t a, input cpc_byte_t exp);
        cpc_byte_t d;
        host_u.rd(a, d);
        chk($sformatf("register %h", a), exp, d);
    endtask

    task automatic oc(input string what, input logic exp, input logic got);
        chk(what, {7'h00, exp}, {7'h00, got});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk_sys);
        num_errors++;
        $display("[ERR] run length expected done seen timeout");
        tally_and_finish();
    end

    initial begin
        {rst, sw, cur_hi, ovp_det, bvl_raw, bcl_raw} = 6'b100000;
        num_errors = 0;
        cmp_count = 0;
        cyc(12);
        rst = 1'b0;
        rchk(`CPC_ADDR_CTRL, `CPC_RST_BYTE);
        rchk(`CPC_ADDR_OVP_STAT, `CPC_RST_BYTE);
        rchk(`CPC_ADDR_OVP_FLAG_MASK, `CPC_RST_BYTE);
        rchk(`CPC_ADDR_FILTER, `CPC_RST_BYTE);
        rchk(8'h30, 8'h00);
        oc("protect", 1'b1, prot);
        // Every control bit set while idle; the reserved bit stays clear.
        host_u.wr(`CPC_ADDR_CTRL, 8'hff);
        rchk(`CPC_ADDR_CTRL, 8'hef);
        oc("rise level", 1'b1, rise);
        oc("sense select", 1'b1, sns);
        oc("pull-down", 1'b1, pd_on);
        oc("protect", 1'b0, prot);
        cyc(30);
        oc("pull-down", 1'b0, pd_on);
        rchk(`CPC_ADDR_CTRL, 8'hee);
        // The rise level write is refused while switching.
        @(negedge clk_sys);
        sw = 1'b1;
        cur_hi = 1'b1;
        host_u.wr(`CPC_ADDR_CTRL, 8'h00);
        rchk(`CPC_ADDR_CTRL, 8'h04);
        oc("rise level", 1'b1, rise);
        sw = 1'b0;
        cur_hi = 1'b0;
        host_u.wr(`CPC_ADDR_CTRL, 8'h00);
        rchk(`CPC_ADDR_CTRL, 8'h00);
        // Register reset clears only its own fields.
        host_u.wr(`CPC_ADDR_FILTER, 8'hff);
        rchk(`CPC_ADDR_FILTER, 8'h18);
        host_u.wr(`CPC_ADDR_CTRL, 8'h4f);
        host_u.rcmd();
        rchk(`CPC_ADDR_FILTER, 8'h00);
        rchk(`CPC_ADDR_CTRL, 8'h4a);
        oc("pull-down", 1'b0, pd_on);
        host_u.wr(`CPC_ADDR_CTRL, 8'h00);
        // Live status, latched flag, read clear and mask.
        host_u.wr(`CPC_ADDR_OVP_STAT, 8'hff);
        rchk(`CPC_ADDR_OVP_STAT, 8'h00);
        ovp_det = 1'b1;
        cyc(3);
        rchk(`CPC_ADDR_OVP_STAT, 8'h01);
        rchk(`CPC_ADDR_OVP_FLAG_MASK, 8'h10);
        oc("irq", 1'b1, irq);
        ovp_det = 1'b0;
        cyc(3);
        rchk(`CPC_ADDR_OVP_STAT, 8'h00);
        oc("irq", 1'b1, irq);
        rchk(`CPC_ADDR_OVP_FLAG_MASK, 8'h10);
        rchk(`CPC_ADDR_OVP_FLAG_MASK, 8'h00);
        oc("irq", 1'b0, irq);
        host_u.wr(`CPC_ADDR_OVP_FLAG_MASK, 8'hff);
        ovp_det = 1'b1;
        cyc(3);
        oc("irq", 1'b0, irq);
        rchk(`CPC_ADDR_OVP_FLAG_MASK, 8'h11);
        ovp_det = 1'b0;
        rchk(`CPC_ADDR_OVP_FLAG_MASK, 8'h11);
        rchk(`CPC_ADDR_OVP_FLAG_MASK, 8'h01);
        host_u.wr(`CPC_ADDR_OVP_FLAG_MASK, 8'h00);
        host_u.wr(`CPC_ADDR_CTRL, 8'h08);
        ovp_det = 1'b1;
        cyc(3);
        rchk(`CPC_ADDR_OVP_STAT, 8'h00);
        oc("irq", 1'b0, irq);
        ovp_det = 1'b0;
        // Soft-start timeout for every code; current above the level stops it.
        for (int c = 0; c < 8; c++) begin
            host_u.wr(`CPC_ADDR_CTRL, cpc_byte_t'(c << 5));
            @(negedge clk_sys);
            sw = 1'b1;
            cyc(c == 0 ? 100 : SS_N[c]);
            oc("fault", 1'b0, fault);
            cyc(4);
            oc("fault", c != 0, fault);
            sw = 1'b0;
        end
        host_u.wr(`CPC_ADDR_CTRL, 8'h20);
        oc("fault", 1'b0, fault);
        @(negedge clk_sys);
        sw = 1'b1;
        cur_hi = 1'b1;
        cyc(30);
        oc("fault", 1'b0, fault);
        {sw, cur_hi} = 2'b00;
        // Short and long error filters with both conditions held.
        for (int l = 0; l < 2; l++) begin
            host_u.wr(`CPC_ADDR_FILTER, l ? 8'h18 : 8'h00);
            @(negedge clk_sys);
            {bvl_raw, bcl_raw} = 2'b11;
            cyc(l ? 15 : 390);
            oc("bus voltage low", 1'b0, bvl_err);
            oc("bus current low", 1'b0, bcl_err);
            cyc(l ? 10 : 20);
            oc("bus current low", 1'b1, bcl_err);
            oc("bus voltage low", l == 0, bvl_err);
            cyc(20);
            oc("bus voltage low", 1'b1, bvl_err);
            {bvl_raw, bcl_raw} = 2'b00;
            cyc(3);
            oc("bus current low", 1'b0, bcl_err);
        end
        tally_and_finish();
    end
endmodule
